/* hdl/crag_cfg.svh */
// Offsets, field positions, write masks and codes of the region access guard
`ifndef CRAG_CFG_SVH
`define CRAG_CFG_SVH
`define CRAG_NUM_REGIONS   16
`define CRAG_NUM_SUBREG    8
`define CRAG_OFS_CTRL      12'h000
`define CRAG_OFS_STATUS    12'h004
`define CRAG_OFS_IRQ_EN    12'h008
`define CRAG_OFS_IRQ_CLR   12'h00C
`define CRAG_OFS_FLT_ADDR  12'h010
`define CRAG_OFS_FLT_INFO  12'h014
`define CRAG_OFS_INFO      12'h018
`define CRAG_OFS_REG_BASE  12'h100
`define CRAG_OFS_REG_STEP  12'h008
`define CRAG_CTRL_ENABLE   0
`define CRAG_CTRL_BGND     1
`define CRAG_CTRL_MASK     32'h0000_0003
`define CRAG_BASE_MASK     32'hFFFF_FFE0
`define CRAG_RCTRL_MASK    32'h173F_FF3F
`define CRAG_RC_EN         0
`define CRAG_RC_SIZE_LO    1
`define CRAG_RC_SRD_LO     8
`define CRAG_RC_ATTR_LO    16
`define CRAG_RC_AP_LO      24
`define CRAG_RC_XN         28
`define CRAG_SIZE_MIN      5'h04
`define CRAG_SIZE_SUBMIN   5'h07
`define CRAG_ST_FAULT      0
`define CRAG_ST_OVER       1
`define CRAG_ST_MASK       2'h3
`define CRAG_AP_NONE       3'h0
`define CRAG_AP_PRW        3'h1
`define CRAG_AP_PRW_URO    3'h2
`define CRAG_AP_RW         3'h3
`define CRAG_AP_PRO        3'h5
`define CRAG_AP_RO         3'h6
`define CRAG_ATTR_DEFAULT  6'h00
`endif

/* hdl/crag_pkg.sv */
// Types of the region access guard
package crag_pkg;
	typedef logic [31:0] crag_word_type;
	typedef logic [3:0]  crag_idx_type;
	typedef logic [5:0]  crag_attr_type;
	typedef logic [2:0]  crag_ap_type;
	typedef logic [1:0]  crag_stat_type;
endpackage

/* hdl/crag_top.sv */
// Region access guard: region compare, permission check, fault capture and Wishbone registers
`include "crag_cfg.svh"

// How it works
// - Nothing is checked until software sets the global enable; all accesses pass.
// - Sixteen regions, each access compared against every enabled region in parallel.
// - Each region of 256 bytes or more has eight subregions, each disableable.
// - Software programs base, size and attributes per region; matching uses them.
// - Size field gives two to the size plus one bytes, 32 bytes up to 4 Gbytes.
// - Access rights decode separately for privileged and unprivileged accesses.
// - A violating access is refused and a fault pulse goes to the core.
// - Matched region memory attributes are returned for every access that hits while enabled; others get the default.
module crag_top
	import crag_pkg::*;
#(
	parameter int NUM_REGIONS = `CRAG_NUM_REGIONS
)
(
	input  wire logic          i_clock,
	input  wire logic          i_srst,
	input  wire logic          i_wb_cyc,
	input  wire logic          i_wb_stb,
	input  wire logic          i_wb_we,
	input  wire logic [11:0]   i_wb_adr,
	input  wire logic [3:0]    i_wb_sel,
	input  wire logic [31:0]   i_wb_dat,
	output logic      [31:0]   o_wb_dat,
	output logic               o_wb_ack,
	input  wire logic          i_acc_valid,
	input  wire logic [31:0]   i_acc_addr,
	input  wire logic          i_acc_write,
	input  wire logic          i_acc_fetch,
	input  wire logic          i_acc_priv,
	output logic               o_acc_done,
	output logic               o_acc_allow,
	output logic               o_acc_fault,
	output logic      [5:0]    o_acc_attr,
	output logic      [3:0]    o_acc_region,
	output logic               o_acc_hit,
	output logic               o_irq
);

	typedef struct packed {
		crag_word_type                       ctrl;
		logic [NUM_REGIONS-1:0][31:0]        base;
		logic [NUM_REGIONS-1:0][31:0]        rctl;
		crag_stat_type                       status;
		crag_stat_type                       irq_en;
		crag_word_type                       flt_addr;
		crag_word_type                       flt_info;
		crag_word_type                       rdat;
		logic                                ack;
		logic                                done;
		logic                                allow;
		logic                                fault;
		crag_attr_type                       attr;
		crag_idx_type                        region;
		logic                                hit;
		logic                                irq;
	} crag_state_type;

	crag_state_type q;
	crag_state_type next_q;

	// Byte-lane merge of a Wishbone write
	function automatic crag_word_type crag_merge(input crag_word_type old_v,
		input crag_word_type new_v, input logic [3:0] sel);
		crag_word_type r;
		r = old_v;
		for (int b = 0; b < 4; b++)
		begin
			if (sel[b])
				r[b*8 +: 8] = new_v[b*8 +: 8];
		end
		return r;
	endfunction

	// Address match of one region, with the subregion disables applied
	function automatic logic crag_hit(input crag_word_type base, input crag_word_type ctl,
		input crag_word_type addr);
		logic [4:0]    sz;
		logic [5:0]    shamt;
		crag_word_type m;
		crag_word_type sh;
		logic [7:0]    srd;
		logic          ok;
		sz = ctl[`CRAG_RC_SIZE_LO +: 5];
		if (sz < `CRAG_SIZE_MIN)
			sz = `CRAG_SIZE_MIN;
		shamt = {1'b0, sz} + 6'h01;
		// A shift by 32 gives zero, so the all-space region masks every bit
		m = ~((32'h0000_0001 << shamt) - 32'h0000_0001);
		// Subregion index is the top three address bits inside the region
		sh = addr >> (sz - 5'h02);
		srd = ctl[`CRAG_RC_SRD_LO +: 8];
		ok = ctl[`CRAG_RC_EN] && ((addr & m) == (base & m));
		if (sz >= `CRAG_SIZE_SUBMIN && srd[sh[2:0]])
			ok = 1'b0;
		return ok;
	endfunction

	// Access rights per privilege level
	function automatic logic crag_perm(input crag_ap_type ap, input logic xn,
		input logic priv, input logic wr, input logic fetch);
		logic rd_ok;
		logic wr_ok;
		rd_ok = 1'b0;
		wr_ok = 1'b0;
		case (ap)
			`CRAG_AP_PRW:
			begin
				rd_ok = priv;
				wr_ok = priv;
			end
			`CRAG_AP_PRW_URO:
			begin
				rd_ok = 1'b1;
				wr_ok = priv;
			end
			`CRAG_AP_RW:
			begin
				rd_ok = 1'b1;
				wr_ok = 1'b1;
			end
			`CRAG_AP_PRO:
			begin
				rd_ok = priv;
			end
			`CRAG_AP_RO:
			begin
				rd_ok = 1'b1;
			end
			default:
			begin
				rd_ok = 1'b0;
			end
		endcase
		if (fetch && xn)
			rd_ok = 1'b0;
		return wr ? wr_ok : rd_ok;
	endfunction

	logic [NUM_REGIONS-1:0] hit_vec;

	genvar gi;
	generate
		for (gi = 0; gi < NUM_REGIONS; gi++)
		begin : g_region
			assign hit_vec[gi] = crag_hit(q.base[gi], q.rctl[gi], i_acc_addr);
		end
	endgenerate

	logic          any_hit;
	crag_idx_type  top_idx;
	crag_word_type top_ctl;
	logic          perm_ok;
	logic          glob_en;
	logic          wb_req;
	logic          ev_fault;
	crag_stat_type clr_bits;
	logic [11:0]   radr;

	assign glob_en = q.ctrl[`CRAG_CTRL_ENABLE];
	assign wb_req  = i_wb_cyc && i_wb_stb && !q.ack;

	always_comb
	begin
		next_q = q;
		any_hit = 1'b0;
		top_idx = 4'h0;
		// Lowest index first, so a later hit overwrites and the highest wins
		for (int i = 0; i < NUM_REGIONS; i++)
		begin
			if (hit_vec[i])
			begin
				any_hit = 1'b1;
				top_idx = i[3:0];
			end
		end
		top_ctl = q.rctl[top_idx];
		perm_ok = crag_perm(top_ctl[`CRAG_RC_AP_LO +: 3], top_ctl[`CRAG_RC_XN],
			i_acc_priv, i_acc_write, i_acc_fetch);
		// Background map only serves privileged code
		if (!any_hit)
			perm_ok = i_acc_priv && q.ctrl[`CRAG_CTRL_BGND];
		if (!glob_en)
			perm_ok = 1'b1;
		ev_fault = i_acc_valid && !perm_ok;

		next_q.done  = i_acc_valid;
		next_q.allow = i_acc_valid && perm_ok;
		next_q.fault = ev_fault;
		next_q.hit   = i_acc_valid && glob_en && any_hit;
		next_q.region = top_idx;
		next_q.attr  = (glob_en && any_hit) ? top_ctl[`CRAG_RC_ATTR_LO +: 6]
			: `CRAG_ATTR_DEFAULT;

		// Unmapped offsets still ack and read zero, so a stray pointer cannot hang the bus
		next_q.ack = wb_req;
		next_q.rdat = 32'h0000_0000;
		clr_bits = 2'h0;
		radr = {i_wb_adr[11:2], 2'b00};
		if (wb_req)
		begin
			if (radr == `CRAG_OFS_CTRL)
			begin
				next_q.rdat = q.ctrl;
				if (i_wb_we)
					next_q.ctrl = crag_merge(q.ctrl, i_wb_dat, i_wb_sel) & `CRAG_CTRL_MASK;
			end
			else if (radr == `CRAG_OFS_STATUS)
				next_q.rdat = {30'h0, q.status};
			else if (radr == `CRAG_OFS_IRQ_EN)
			begin
				next_q.rdat = {30'h0, q.irq_en};
				if (i_wb_we && i_wb_sel[0])
					next_q.irq_en = i_wb_dat[1:0];
			end
			else if (radr == `CRAG_OFS_IRQ_CLR)
			begin
				if (i_wb_we && i_wb_sel[0])
					clr_bits = i_wb_dat[1:0];
			end
			else if (radr == `CRAG_OFS_FLT_ADDR)
				next_q.rdat = q.flt_addr;
			else if (radr == `CRAG_OFS_FLT_INFO)
				next_q.rdat = q.flt_info;
			else if (radr == `CRAG_OFS_INFO)
				next_q.rdat = {24'h0, 8'(NUM_REGIONS)};
			else if (radr >= `CRAG_OFS_REG_BASE
				&& radr < `CRAG_OFS_REG_BASE + 12'(NUM_REGIONS) * `CRAG_OFS_REG_STEP)
			begin
				if (radr[2])
				begin
					next_q.rdat = q.rctl[radr[6:3]];
					if (i_wb_we)
						next_q.rctl[radr[6:3]] = crag_merge(q.rctl[radr[6:3]], i_wb_dat,
							i_wb_sel) & `CRAG_RCTRL_MASK;
				end
				else
				begin
					next_q.rdat = q.base[radr[6:3]];
					if (i_wb_we)
						next_q.base[radr[6:3]] = crag_merge(q.base[radr[6:3]], i_wb_dat,
							i_wb_sel) & `CRAG_BASE_MASK;
				end
			end
		end

		// A fault in the clearing cycle stays set
		next_q.status = q.status & ~clr_bits;
		if (ev_fault)
		begin
			next_q.status[`CRAG_ST_FAULT] = 1'b1;
			if (q.status[`CRAG_ST_FAULT])
				next_q.status[`CRAG_ST_OVER] = 1'b1;
			next_q.flt_addr = i_acc_addr;
			next_q.flt_info = {19'h0, any_hit, top_idx, 5'h0, i_acc_priv, i_acc_fetch,
				i_acc_write};
		end
		next_q.irq = |(next_q.status & next_q.irq_en);
	end

	always_ff @(posedge i_clock)
	begin
		if (i_srst)
			q <= '0;
		else
			q <= next_q;
	end

	assign o_wb_dat     = q.rdat;
	assign o_wb_ack     = q.ack;
	assign o_acc_done   = q.done;
	assign o_acc_allow  = q.allow;
	assign o_acc_fault  = q.fault;
	assign o_acc_attr   = q.attr;
	assign o_acc_region = q.region;
	assign o_acc_hit    = q.hit;
	assign o_irq        = q.irq;

	default clocking cb @(posedge i_clock); endclocking
	default disable iff (i_srst);

	a_inactive_pass: assert property (i_acc_valid && !glob_en |=>
		o_acc_allow && !o_acc_fault)
		else $error("access refused while guard disabled");
	a_check_latency: assert property (i_acc_valid |=> o_acc_done)
		else $error("access not answered in one cycle");
	a_fault_excl: assert property (o_acc_done |-> (o_acc_allow != o_acc_fault))
		else $error("allow and fault not exclusive");
	a_fault_sticky: assert property (o_acc_fault |-> q.status[`CRAG_ST_FAULT])
		else $error("fault did not set status");
	a_top_region: assert property (i_acc_valid && glob_en && any_hit
		|=> o_acc_hit && o_acc_region == $past(top_idx))
		else $error("wrong matched region");
	a_attr_pass: assert property (i_acc_valid && glob_en && any_hit
		|=> o_acc_attr == $past(top_ctl[21:16]))
		else $error("attributes not passed");
	a_user_nomatch: assert property (i_acc_valid && glob_en && !any_hit && !i_acc_priv
		|=> o_acc_fault)
		else $error("unprivileged miss not faulted");
	a_irq_level: assert property (o_irq == |(q.status & q.irq_en))
		else $error("interrupt level wrong");
	a_ack_answer: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack |=>
		o_wb_ack ##1 !o_wb_ack)
		else $error("bus ack not single cycle");

	// Fault capture, output and bus checks, so a lost overrun or a stale address shows up at once
	a_fault_addr: assert property (ev_fault |=> q.flt_addr == $past(i_acc_addr))
		else $error("fault address not captured");
	a_fault_set: assert property (ev_fault |=> q.status[`CRAG_ST_FAULT])
		else $error("fault flag lost against clear");
	a_over_flag: assert property (ev_fault && q.status[`CRAG_ST_FAULT] |=>
		q.status[`CRAG_ST_OVER])
		else $error("overrun not flagged");
	a_idle_quiet: assert property (!i_acc_valid |=> !o_acc_done && !o_acc_fault)
		else $error("answer without request");
	a_miss_nohit: assert property (i_acc_valid && !any_hit |=> !o_acc_hit)
		else $error("hit flagged without match");
	a_off_nohit: assert property (i_acc_valid && !glob_en |=> !o_acc_hit)
		else $error("hit flagged while guard disabled");
	a_priv_bgnd: assert property (i_acc_valid && glob_en && !any_hit && i_acc_priv
		&& q.ctrl[`CRAG_CTRL_BGND] |=> o_acc_allow)
		else $error("privileged background access refused");
	a_attr_default: assert property (i_acc_valid && !(glob_en && any_hit) |=>
		o_acc_attr == `CRAG_ATTR_DEFAULT)
		else $error("attributes without a match");
	a_fetch_xn: assert property (i_acc_valid && glob_en && any_hit && i_acc_fetch
		&& !i_acc_write && top_ctl[`CRAG_RC_XN] |=> o_acc_fault)
		else $error("fetch from no-execute region allowed");
	a_rdat_idle: assert property (!o_wb_ack |-> o_wb_dat == 32'h0000_0000)
		else $error("read data outside ack");
	a_hit_done: assert property (o_acc_hit |-> o_acc_done)
		else $error("hit without answer");

	c_fault_seen: cover property (i_acc_valid && glob_en ##1 o_acc_fault);
	c_overlap: cover property (i_acc_valid && glob_en && $countones(hit_vec) > 1);
	c_sub_hit: cover property (i_acc_valid && glob_en && any_hit ##1 o_acc_allow);
	c_irq_raise: cover property (!o_irq ##1 o_irq);
	c_overrun: cover property (ev_fault && q.status[`CRAG_ST_FAULT]);

endmodule

/* tb/cpu_region_access_guard_bench.sv */
// Bench of the region access guard: Wishbone setup, directed and random checks
module cpu_region_access_guard_bench;
	import crag_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic i_clock, i_srst, cyc, stb, we, ack, valid, wr, fe, pr;
	logic done, allow, fault, hit, irq;
	logic [11:0] adr;
	logic [3:0] sel, region;
	logic [5:0] attr;
	crag_word_type wdat, rdat, addr, rd;
	int fail_count, n_compared, i;
	int seed = 32'h6070;
	logic [31:0] r;
	crag_top i_crag_top (.i_clock(i_clock), .i_srst(i_srst), .i_wb_cyc(cyc),
		.i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel),
		.i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack), .i_acc_valid(valid),
		.i_acc_addr(addr), .i_acc_write(wr), .i_acc_fetch(fe), .i_acc_priv(pr),
		.o_acc_done(done), .o_acc_allow(allow), .o_acc_fault(fault),
		.o_acc_attr(attr), .o_acc_region(region), .o_acc_hit(hit), .o_irq(irq));
	crag_core_model i_crag_core_model (.i_clock(i_clock), .o_valid(valid),
		.o_addr(addr), .o_write(wr), .o_fetch(fe), .o_priv(pr));
	initial
	begin
		i_clock = 1'b0;
		forever #10 i_clock = ~i_clock;
	end
	task automatic wrap_up();
		if (fail_count == 0 && n_compared > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wb(input logic w, input logic [11:0] a, input crag_word_type d);
		int k;
		@(posedge i_clock);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		sel <= 4'hF;
		for (k = 0; k < 20 && ack !== 1'b1; k++)
			@(posedge i_clock);
		if (ack !== 1'b1)
		begin
			fail_count++;
			wrap_up();
		end
		rd = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask
	// Expected verdict {allow, hit, region, attr}; regions 5 and 2 overlap at the base
	function automatic logic [11:0] exp_acc(input crag_word_type a, input logic w,
		input logic f, input logic p);
		if (a[31:8] == 24'h20_0000)
			return {p & ~w, 1'b1, 4'h5, 6'h2A};
		if (a[31:10] == 22'h08_0000 && a[9:7] != 3'h3)
			return {~f, 1'b1, 4'h2, 6'h15};
		return {p, 1'b0, 4'h0, 6'h00};
	endfunction
	task automatic acc(input crag_word_type a, input logic w, input logic f,
		input logic p, input logic [11:0] e);
		i_crag_core_model.issue(a, w, f, p);
		#1;
		chk("done", done, 1'b1);
		chk("allow", allow, e[11]);
		chk("fault", fault, !e[11]);
		chk("hit", hit, e[10]);
		chk("attr", attr, e[5:0]);
		if (e[10])
			chk("region", region, e[9:6]);
	endtask
	task automatic acc_auto(input crag_word_type a, input logic w, input logic f,
		input logic p);
		acc(a, w, f, p, exp_acc(a, w, f, p));
	endtask
	initial
	begin
		{cyc, stb, we, adr, sel, wdat, fail_count, n_compared} = '0;
		i_srst = 1'b1;
		repeat (2) @(posedge i_clock);
		i_srst <= 1'b0;
		wb(1'b0, 12'h018, 32'h0);
		chk("info", rd, 32'h10);
		wb(1'b0, 12'h080, 32'h0);
		chk("unmapped", rd, 32'h0);
		wb(1'b1, 12'h110, 32'h2000_0000);
		wb(1'b1, 12'h114, 32'h1315_0813);
		wb(1'b1, 12'h128, 32'h2000_0000);
		wb(1'b1, 12'h12C, 32'h052A_000F);
		wb(1'b0, 12'h114, 32'h0);
		chk("rctl2", rd, 32'h1315_0813);
		acc(32'h2000_0010, 1'b1, 1'b0, 1'b0, 12'h800);
		wb(1'b1, 12'h000, 32'h3);
		wb(1'b1, 12'h008, 32'h1);
		acc_auto(32'h2000_0010, 1'b1, 1'b0, 1'b1);
		chk("irq", irq, 1'b1);
		wb(1'b0, 12'h010, 32'h0);
		chk("fault addr", rd, 32'h2000_0010);
		wb(1'b1, 12'h004, 32'h0);
		wb(1'b0, 12'h004, 32'h0);
		chk("status", rd, 32'h1);
		wb(1'b1, 12'h008, 32'h0);
		chk("irq masked", irq, 1'b0);
		wb(1'b1, 12'h00C, 32'h3);
		wb(1'b0, 12'h004, 32'h0);
		chk("status clr", rd, 32'h0);
		acc_auto(32'h2000_00FF, 1'b0, 1'b0, 1'b1);
		acc_auto(32'h2000_0010, 1'b0, 1'b0, 1'b0);
		acc_auto(32'h2000_0100, 1'b1, 1'b0, 1'b0);
		acc_auto(32'h2000_0180, 1'b0, 1'b0, 1'b0);
		acc_auto(32'h2000_01C0, 1'b0, 1'b0, 1'b1);
		acc_auto(32'h2000_0300, 1'b0, 1'b1, 1'b1);
		wb(1'b0, 12'h014, 32'h0);
		chk("fault info", rd, 32'h0000_1206);
		acc_auto(32'h2000_0400, 1'b0, 1'b0, 1'b0);
		for (i = 0; i < 300; i++)
		begin
			r = $random(seed);
			acc_auto(32'h2000_0000 | (r & 32'h7FF), r[12] & ~r[13], r[13], r[14]);
		end
		wb(1'b0, 12'h004, 32'h0);
		chk("status overrun", rd, 32'h3);
		wrap_up();
	end
endmodule

/* tb/crag_core_model.sv */
// Core load/store and fetch path model issuing one check request at a time
module crag_core_model
	import crag_pkg::*;
(
	input  wire logic    i_clock,
	output logic          o_valid,
	output crag_word_type o_addr,
	output logic          o_write,
	output logic          o_fetch,
	output logic          o_priv
);
	timeunit 1ns;
	timeprecision 1ps;
	initial
	begin
		o_valid = 1'b0;
		o_addr = 32'h0000_0000;
		o_write = 1'b0;
		o_fetch = 1'b0;
		o_priv = 1'b0;
	end
	// Qualifiers are scrambled between requests so stale values never look valid
	task automatic issue(input crag_word_type a, input logic w, input logic f, input logic p);
		@(posedge i_clock);
		o_valid <= 1'b1;
		o_addr <= a;
		o_write <= w;
		o_fetch <= f;
		o_priv <= p;
		@(posedge i_clock);
		o_valid <= 1'b0;
		o_addr <= ~a;
		o_write <= ~w;
		o_fetch <= ~f;
		o_priv <= ~p;
	endtask
endmodule
